// file: swgc_regs.sv
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "swgc_cfg.svh"

// Overview of operation
// - Mirror select set: mirror only when source and destination both monitored.
// - Mirror select clear: mirror when source or destination is monitored.
// - Mirror select resets to zero, giving source-or-destination mirroring by default.
// - Uplink bit 7 enables half-duplex back pressure; resets to zero.
// - Uplink bit 6 picks half duplex when set, full duplex when clear.
// - Uplink bit 5 enables full-duplex flow control; resets to zero.
// - Uplink bit 4 selects 10 Mbps when set, 100 Mbps when clear.
// - Null-VLAN_IDENTIFIER bit set replaces a zero tag identifier by the port default.
// - Storm limit is 11 bits: uplink bits 2..0 high, next register low.
// - Storm window lasts 50 ms at 100 Mbps, 500 ms at 10 Mbps.
// - Low storm-rate register resets to 4A, high rate bits to zero.
// - Writing flush clears statistics counters of every enabled port.
// - Flush bit reads one while running and clears itself when done.
// - Freeze bit stops counting on enabled ports until it is cleared.
// - Enable bits 0,1,2 serve ports 1..3, bit 4 uplink, bit 3 reserved.
// - Ports with enable clear ignore flush and freeze; enables reset to zero.
// - Separate bit chooses broadcast-only or broadcast plus multicast regulation.
module swgc_regs
#(
  parameter int WIN_CYC = `SWGC_WIN100_MS * `SWGC_CLK_KHZ,
  parameter int LIM_W   = 11
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Mirror decision
  input  wire logic        mir_valid,
  input  wire logic        mir_src_mon,
  input  wire logic        mir_dst_mon,
  output logic             mir_hit_valid,
  output logic             mir_hit,
  // Uplink switch port settings
  output logic             up_bp_en,
  output logic             up_half_duplex,
  output logic             up_fc_en,
  output logic             up_speed_10m,
  // Null vlan_identifier replacement
  input  wire logic        tag_valid,
  input  wire logic [11:0] tag_vlan_identifier,
  input  wire logic [11:0] port_vlan_identifier,
  output logic             vid_out_valid,
  output logic      [11:0] vid_out,
  // Storm protection, index 3 is the uplink_switch_port
  input  wire logic [2:0]  port_speed_10m,
  input  wire logic [3:0]  rx_blk,
  input  wire logic [3:0]  rx_da_bcast,
  input  wire logic [3:0]  rx_da_mcast,
  output logic      [3:0]  storm_drop,
  // Statistics counter control
  output logic      [3:0]  stat_flush_req,
  input  wire logic        stat_flush_done,
  output logic      [3:0]  stat_freeze
);

  localparam int WIN_W = $clog2(WIN_CYC + 1);

  typedef struct packed {
    swgc_pkg::swgc_regs_t r;
    logic [WIN_W-1:0]     win;
    logic [7:0]           rdata;
    logic                 mir_vld;
    logic                 mir_hit;
    logic                 vid_vld;
    logic [11:0]          vlan_identifier;
  } swgc_st_t;

  swgc_st_t         st_q;
  swgc_st_t         st_d;
  logic             win_tick;
  logic [3:0]       en4;
  logic [3:0]       spd4;
  logic [3:0]       blk_reg;
  logic [LIM_W-1:0] limit;

  generate
    if (WIN_CYC < 2 || LIM_W != 11)
    begin : g_chk
      $error("swgc_regs: bad parameter");
    end
  endgenerate

  // ****************************************************************
  // Derived controls
  // ****************************************************************
  assign en4   = {st_q.r.cnt_en[4], st_q.r.cnt_en[2:0]};
  assign spd4  = {st_q.r.up_spd10, port_speed_10m};
  assign limit = {st_q.r.rate_hi, st_q.r.rate_lo};
  assign win_tick = (st_q.win == WIN_W'(WIN_CYC - 1));

  // Multicast counts only while the class bit allows it
  assign blk_reg = rx_da_bcast | (rx_da_mcast & {4{~st_q.r.mc_dis}});

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = 8'h00;
    st_d.win = win_tick ? '0 : st_q.win + WIN_W'(1);

    // Mirror decision, one cycle after the request
    st_d.mir_vld = mir_valid;
    if (st_q.r.mir_sel)
    begin
      st_d.mir_hit = mir_valid && mir_src_mon && mir_dst_mon;
    end
    else
    begin
      st_d.mir_hit = mir_valid && (mir_src_mon || mir_dst_mon);
    end

    // Tag identifier passes or takes the port default
    st_d.vid_vld = tag_valid;
    if (tag_valid)
    begin
      if (st_q.r.null_en && tag_vlan_identifier == `SWGC_NULL_VID)
      begin
        st_d.vlan_identifier = port_vlan_identifier;
      end
      else
      begin
        st_d.vlan_identifier = tag_vlan_identifier;
      end
    end

    // Flush finishes on the counter store's answer, or next cycle with no port enabled
    if (st_q.r.flush && (stat_flush_done || en4 == 4'h0))
    begin
      st_d.r.flush = 1'b0;
    end

    if (wr)
    begin
      case (addr)
        `SWGC_A_STORM_CLASS:
        begin
          st_d.r.mc_dis = wdata[`SWGC_B_MC_DIS];
        end
        `SWGC_A_MIRROR:
        begin
          st_d.r.mir_sel = wdata[`SWGC_B_MIR_SEL];
        end
        `SWGC_A_UPLINK:
        begin
          st_d.r.up_bp    = wdata[`SWGC_B_UP_BP];
          st_d.r.up_hdx   = wdata[`SWGC_B_UP_HDX];
          st_d.r.up_fc    = wdata[`SWGC_B_UP_FC];
          st_d.r.up_spd10 = wdata[`SWGC_B_UP_SPD10];
          st_d.r.null_en  = wdata[`SWGC_B_NULL_VID];
          st_d.r.rate_hi  = wdata[`SWGC_B_RATE_HI_MSB:0];
        end
        `SWGC_A_RATE_LO:
        begin
          st_d.r.rate_lo = wdata;
        end
        `SWGC_A_CNT_CTL:
        begin
          // A running flush cannot be cancelled by writing zero
          st_d.r.flush  = st_d.r.flush | wdata[`SWGC_B_FLUSH];
          st_d.r.freeze = wdata[`SWGC_B_FREEZE];
          st_d.r.cnt_en = wdata[`SWGC_B_EN_MSB:0] & `SWGC_EN_MASK;
        end
        default:
        begin
          st_d.r = st_d.r;
        end
      endcase
    end

    if (rd)
    begin
      case (addr)
        `SWGC_A_STORM_CLASS:
        begin
          st_d.rdata[`SWGC_B_MC_DIS] = st_q.r.mc_dis;
        end
        `SWGC_A_MIRROR:
        begin
          st_d.rdata[`SWGC_B_MIR_SEL] = st_q.r.mir_sel;
        end
        `SWGC_A_UPLINK:
        begin
          st_d.rdata = {st_q.r.up_bp, st_q.r.up_hdx, st_q.r.up_fc,
                        st_q.r.up_spd10, st_q.r.null_en, st_q.r.rate_hi};
        end
        `SWGC_A_RATE_LO:
        begin
          st_d.rdata = st_q.r.rate_lo;
        end
        `SWGC_A_CNT_CTL:
        begin
          st_d.rdata = {st_q.r.flush, st_q.r.freeze, 1'b0,
                        st_q.r.cnt_en};
        end
        default:
        begin
          // Unmapped and foreign offsets read zero
          st_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_q           <= '0;
      st_q.r.mc_dis  <= `SWGC_RST_MC_DIS;
      st_q.r.rate_hi <= `SWGC_RST_RATE_HI;
      st_q.r.rate_lo <= `SWGC_RST_RATE_LO;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata          = st_q.rdata;
  assign mir_hit_valid  = st_q.mir_vld;
  assign mir_hit        = st_q.mir_hit;
  assign up_bp_en       = st_q.r.up_bp;
  assign up_half_duplex = st_q.r.up_hdx;
  assign up_fc_en       = st_q.r.up_fc;
  assign up_speed_10m   = st_q.r.up_spd10;
  assign vid_out_valid  = st_q.vid_vld;
  assign vid_out        = st_q.vlan_identifier;
  assign stat_flush_req = {4{st_q.r.flush}} & en4;
  assign stat_freeze    = {4{st_q.r.freeze}} & en4;

  // ****************************************************************
  // Storm counters, one per input port
  // ****************************************************************
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++)
    begin : g_port
      swgc_storm_port
      #(
        .LIM_W (LIM_W)
      )
      u_storm
      (
        .clk      (clk),
        .rst_b    (rst_b),
        .win_tick (win_tick),
        .spd10    (spd4[gp]),
        .limit    (limit),
        .blk      (rx_blk[gp]),
        .blk_reg  (blk_reg[gp]),
        .drop     (storm_drop[gp])
      );
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_flush_wr;
    wr && addr == `SWGC_A_CNT_CTL && wdata[`SWGC_B_FLUSH];
  endsequence

  sequence s_flush_run;
    st_q.r.flush && !stat_flush_done && en4 != 4'h0;
  endsequence

  AST_MIR_AND: assert property (
    mir_valid && st_q.r.mir_sel && !(wr && addr == `SWGC_A_MIRROR)
    |=> mir_hit == ($past(mir_src_mon) && $past(mir_dst_mon)))
    else $error("mirror and-match wrong");

  AST_MIR_OR: assert property (
    mir_valid && !st_q.r.mir_sel
    |=> mir_hit == ($past(mir_src_mon) || $past(mir_dst_mon)))
    else $error("mirror or-match wrong");

  AST_RST_VAL: assert property (
    $rose(rst_b) |-> !st_q.r.mir_sel && en4 == 4'h0
    && limit == {`SWGC_RST_RATE_HI, `SWGC_RST_RATE_LO})
    else $error("reset values wrong");

  AST_UPLINK: assert property (
    wr && addr == `SWGC_A_UPLINK
    |=> up_bp_en == $past(wdata[`SWGC_B_UP_BP])
        && up_half_duplex == $past(wdata[`SWGC_B_UP_HDX])
        && up_fc_en == $past(wdata[`SWGC_B_UP_FC])
        && up_speed_10m == $past(wdata[`SWGC_B_UP_SPD10]))
    else $error("uplink settings not stored");

  AST_NULL_VID: assert property (
    tag_valid && st_q.r.null_en && tag_vlan_identifier == `SWGC_NULL_VID
    |=> vid_out_valid && vid_out == $past(port_vlan_identifier))
    else $error("null identifier not replaced");

  AST_RATE_LO: assert property (
    wr && addr == `SWGC_A_RATE_LO |=> limit[7:0] == $past(wdata))
    else $error("low rate not stored");

  AST_FLUSH_REQ: assert property (
    s_flush_wr ##1 s_flush_run |-> stat_flush_req == en4 ##1 st_q.r.flush)
    else $error("flush request wrong");

  AST_FLUSH_SC: assert property (
    st_q.r.flush && stat_flush_done
    && !(wr && addr == `SWGC_A_CNT_CTL && wdata[`SWGC_B_FLUSH])
    |=> !st_q.r.flush)
    else $error("flush did not clear itself");

  AST_GATE: assert property (
    ((stat_freeze | stat_flush_req) & ~en4) == 4'h0 ##1
    (stat_freeze & ~en4) == 4'h0)
    else $error("disabled port affected");

  AST_RSV_RD: assert property (
    rd && addr == `SWGC_A_CNT_CTL
    |=> rdata[`SWGC_B_CNT_RSV] == 1'b0 && rdata[`SWGC_B_EN_RSV] == 1'b0)
    else $error("reserved bits read nonzero");

  AST_RD_IDLE: assert property (
    !rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");

endmodule

// file: swgc_cfg.svh
`ifndef SWGC_CFG_SVH
`define SWGC_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SWGC_A_STORM_CLASS 8'h04
`define SWGC_A_MIRROR      8'h05
`define SWGC_A_UPLINK      8'h06
`define SWGC_A_RATE_LO     8'h07
`define SWGC_A_CNT_CTL     8'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define SWGC_B_MC_DIS      6
`define SWGC_B_MIR_SEL     0
`define SWGC_B_UP_BP       7
`define SWGC_B_UP_HDX      6
`define SWGC_B_UP_FC       5
`define SWGC_B_UP_SPD10    4
`define SWGC_B_NULL_VID    3
`define SWGC_B_RATE_HI_MSB 2
`define SWGC_B_FLUSH       7
`define SWGC_B_FREEZE      6
`define SWGC_B_EN_MSB      4
`define SWGC_B_CNT_RSV     5
`define SWGC_B_EN_RSV      3
`define SWGC_EN_MASK       5'h17

// ****************************************************************
// Reset values
// ****************************************************************
`define SWGC_RST_MC_DIS    1'h1
`define SWGC_RST_RATE_HI   3'h0
`define SWGC_RST_RATE_LO   8'h4A
`define SWGC_NULL_VID      12'h000

// ****************************************************************
// Timing
// ****************************************************************
`define SWGC_CLK_KHZ       40000
`define SWGC_WIN100_MS     50
`define SWGC_WIN10_MS      500

`endif

// file: swgc_pkg.sv
package swgc_pkg;

  typedef struct packed {
    logic       mc_dis;
    logic       mir_sel;
    logic       up_bp;
    logic       up_hdx;
    logic       up_fc;
    logic       up_spd10;
    logic       null_en;
    logic [2:0] rate_hi;
    logic [7:0] rate_lo;
    logic       flush;
    logic       freeze;
    logic [4:0] cnt_en;
  } swgc_regs_t;

endpackage

// file: swgc_storm_port.sv
`timescale 1ns/10ps
`include "swgc_cfg.svh"

module swgc_storm_port
#(
  parameter int LIM_W    = 11,
  parameter int WIN_MULT = `SWGC_WIN10_MS / `SWGC_WIN100_MS
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Window base tick and port speed
  input  wire logic             win_tick,
  input  wire logic             spd10,
  // Limit and traffic
  input  wire logic [LIM_W-1:0] limit,
  input  wire logic             blk,
  input  wire logic             blk_reg,
  // Discard indication
  output logic                  drop
);

  localparam int DIV_W = $clog2(WIN_MULT + 1);

  typedef struct packed {
    logic [LIM_W-1:0] cnt;
    logic [DIV_W-1:0] div;
  } swgc_sp_st_t;

  swgc_sp_st_t st_q;
  swgc_sp_st_t st_d;
  logic        win_end;

  generate
    if (WIN_MULT < 1 || LIM_W < 1)
    begin : g_chk
      $error("swgc_storm_port: bad parameter");
    end
  endgenerate

  // ****************************************************************
  // Window and block count
  // ****************************************************************
  // Slow ports stretch the base window by the speed ratio
  assign win_end = win_tick &&
                   (!spd10 || st_q.div == DIV_W'(WIN_MULT - 1));

  always_comb
  begin
    st_d = st_q;
    if (win_tick)
    begin
      st_d.div = win_end ? '0 : st_q.div + DIV_W'(1);
    end
    if (win_end)
    begin
      st_d.cnt = '0;
    end
    else if (blk && blk_reg && st_q.cnt < limit)
    begin
      st_d.cnt = st_q.cnt + LIM_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Saturated count means the window budget is spent
  assign drop = (st_q.cnt >= limit);

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_CNT_CAP: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(st_q.cnt) && st_q.cnt != '0 |-> st_q.cnt <= limit)
    else $error("storm count passed the limit");

  AST_WIN_CLR: assert property (@(posedge clk) disable iff (!rst_b)
    win_end |=> st_q.cnt == '0)
    else $error("storm count not cleared at window end");

endmodule

// file: swgc_regs_tb_top.sv
`timescale 1ns/10ps

module swgc_regs_tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int WIN = 20;
  logic        clk, rst_b, wr, rd, mir_valid, mir_src_mon, mir_dst_mon;
  logic        mir_hit_valid, mir_hit, up_bp_en, up_half_duplex;
  logic        up_fc_en, up_speed_10m, tag_valid, vid_out_valid;
  logic        stat_flush_done, fr;
  logic [7:0]  addr, wdata, rdata, m6, v;
  logic [11:0] tag_vlan_identifier, port_vlan_identifier, vid_out, id;
  logic [2:0]  port_speed_10m;
  logic [3:0]  rx_blk, rx_da_bcast, rx_da_mcast, storm_drop;
  logic [3:0]  stat_flush_req, stat_freeze, ex;
  logic [4:0]  en;
  int          n_errors, checks, cyc, t_fall, t0, s, d, k, bp;
  // Register image kept from the rules, offsets 04..08
  logic [7:0]  mdl [4:8];
  localparam logic [7:0] MSK [4:8] = '{8'h40, 8'h01, 8'hFF, 8'hFF, 8'h57};

  // Short window keeps the storm checks inside a few hundred cycles
  swgc_regs #(.WIN_CYC(WIN), .LIM_W(11)) swgc_regs_inst (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .mir_valid(mir_valid),
    .mir_src_mon(mir_src_mon), .mir_dst_mon(mir_dst_mon),
    .mir_hit_valid(mir_hit_valid), .mir_hit(mir_hit),
    .up_bp_en(up_bp_en), .up_half_duplex(up_half_duplex),
    .up_fc_en(up_fc_en), .up_speed_10m(up_speed_10m),
    .tag_valid(tag_valid), .tag_vlan_identifier(tag_vlan_identifier),
    .port_vlan_identifier(port_vlan_identifier),
    .vid_out_valid(vid_out_valid), .vid_out(vid_out),
    .port_speed_10m(port_speed_10m), .rx_blk(rx_blk),
    .rx_da_bcast(rx_da_bcast), .rx_da_mcast(rx_da_mcast),
    .storm_drop(storm_drop), .stat_flush_req(stat_flush_req),
    .stat_flush_done(stat_flush_done), .stat_freeze(stat_freeze));

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Write lands at the strobe edge; settle one more edge before use
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clk);
    addr  <= a;
    wdata <= dv;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
    // Flush self-clears, so the model keeps only the lasting bits
    if (a >= 8'h04 && a <= 8'h08)
      mdl[a] = dv & MSK[a];
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic mir(input logic sv, input logic dv, input logic e);
    @(posedge clk);
    mir_valid   <= 1'b1;
    mir_src_mon <= sv;
    mir_dst_mon <= dv;
    @(posedge clk);
    mir_valid <= 1'b0;
    #1;
    chk(mir_hit_valid, 1'b1);
    chk(mir_hit, e);
  endtask

  task automatic tag(input logic [11:0] t, input logic [11:0] p,
                     input logic [11:0] e);
    @(posedge clk);
    tag_valid            <= 1'b1;
    tag_vlan_identifier  <= t;
    port_vlan_identifier <= p;
    @(posedge clk);
    tag_valid <= 1'b0;
    #1;
    chk(vid_out_valid, 1'b1);
    chk(vid_out, e);
  endtask

  task automatic blk(input logic bc, input logic mc);
    @(posedge clk);
    rx_blk      <= 4'h1 << bp;
    rx_da_bcast <= 4'(bc) << bp;
    rx_da_mcast <= 4'(mc) << bp;
    @(posedge clk);
    rx_blk <= 4'h0;
    #1;
  endtask

  // Fill the port picked by bp to its limit, then wait for the window to roll over
  task automatic sync_win();
    int i;
    for (i = 0; i < 20 && storm_drop[bp] !== 1'b1; i++)
      blk(1'b1, 1'b0);
    // Bound covers the stretched window of a 10 Mbps port
    for (i = 0; i < 30 * WIN && storm_drop[bp] !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    t_fall = cyc;
  endtask

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial
  begin
    #(25 * 20000);
    n_errors++;
    final_report();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {clk, rst_b, wr, rd, mir_valid, mir_src_mon, mir_dst_mon} = '0;
    {tag_valid, stat_flush_done, addr, wdata, rx_blk} = '0;
    {tag_vlan_identifier, port_vlan_identifier} = '0;
    {rx_da_bcast, rx_da_mcast} = '0;
    port_speed_10m = 3'h2;
    {n_errors, checks, cyc, bp} = '0;
    mdl = '{8'h40, 8'h00, 8'h00, 8'h4A, 8'h00};
    void'($urandom(32'h4B6CDF59));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(8'h04, 8'h40);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h07, 8'h4A);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h00);
    chk({up_bp_en, up_half_duplex, up_fc_en, up_speed_10m}, 4'h0);
    // Uplink settings and upper rate bits
    repeat (4)
    begin
      v = 8'($urandom);
      wr_reg(8'h06, v);
      chk(up_bp_en, v[7]);
      chk(up_half_duplex, v[6]);
      chk(up_fc_en, v[5]);
      chk(up_speed_10m, v[4]);
      rd_chk(8'h06, v);
    end
    // Unmapped write must leave mapped registers alone
    wr_reg(8'h0A, 8'hFF);
    rd_chk(8'h06, v);
    // Mirror match, every select and monitor combination
    for (k = 0; k < 2; k++)
    begin
      wr_reg(8'h05, 8'hFE | 8'(k));
      rd_chk(8'h05, 8'(k));
      for (s = 0; s < 4; s++)
        mir(s[0], s[1], k ? (s[0] & s[1]) : (s[0] | s[1]));
    end
    // Null identifier replacement on and off
    for (k = 0; k < 2; k++)
    begin
      m6 = (8'($urandom) & 8'hF7) | (k ? 8'h08 : 8'h00);
      wr_reg(8'h06, m6);
      id = 12'($urandom) | 12'h001;
      tag(12'h000, id, k ? id : 12'h000);
      tag(id, 12'h123, id);
    end
    // Storm limit of three blocks, broadcast only after reset
    wr_reg(8'h06, 8'h00);
    wr_reg(8'h07, 8'h03);
    sync_win();
    t0 = t_fall;
    blk(1'b0, 1'b1);
    blk(1'b0, 1'b1);
    chk(storm_drop[0], 1'b0);
    blk(1'b1, 1'b0);
    blk(1'b1, 1'b0);
    chk(storm_drop[0], 1'b0);
    blk(1'b1, 1'b0);
    chk(storm_drop, 4'h1);
    sync_win();
    chk(12'(t_fall - t0), 12'(WIN));
    // Multicast regulated once the class bit is cleared
    wr_reg(8'h04, 8'h00);
    rd_chk(8'h04, 8'h00);
    sync_win();
    repeat (3) blk(1'b0, 1'b1);
    chk(storm_drop[0], 1'b1);
    // Port 2 runs at 10 Mbps: window ten times longer
    bp = 1;
    sync_win();
    t0 = t_fall;
    sync_win();
    chk(12'(t_fall - t0), 12'(10 * WIN));
    // Uplink speed bit stretches the uplink window the same way
    wr_reg(8'h06, 8'h10);
    bp = 3;
    sync_win();
    t0 = t_fall;
    sync_win();
    chk(12'(t_fall - t0), 12'(10 * WIN));
    bp = 0;
    // Flush and freeze with random enable sets
    repeat (5)
    begin
      en = 5'($urandom);
      fr = 1'($urandom);
      ex = {en[4], en[2:0]};
      wr_reg(8'h08, {1'b1, fr, 1'b0, en});
      chk(stat_flush_req, ex);
      chk(stat_freeze, fr ? ex : 4'h0);
      rd_chk(8'h08, {(ex != 4'h0), fr, 1'b0, en & 5'h17});
      @(posedge clk);
      stat_flush_done <= 1'b1;
      @(posedge clk);
      stat_flush_done <= 1'b0;
      @(posedge clk);
      #1;
      chk(stat_flush_req, 4'h0);
      rd_chk(8'h08, {1'b0, fr, 1'b0, en & 5'h17});
      wr_reg(8'h08, 8'h00);
      chk(stat_freeze, 4'h0);
    end
    // Every mapped register against the model
    for (k = 4; k <= 8; k++)
      rd_chk(8'(k), mdl[k]);
    final_report();
  end
endmodule
